// File: hdl/power_acc_pkg.sv
`default_nettype none
package power_acc_pkg;
  // widths
  localparam int ACC_W = 40;
  localparam int DIAG_W = 16;
  localparam int ADDR_W = 6;
  localparam int CURRENT_W = 16;
  localparam int VBUS_W = 15;
  localparam int TEMP_W = 12;
  localparam int POWER_W = 24;
  localparam int PLIMIT_W = 16;
  localparam int LIMIT_N = 6;
  // power limit compares against the upper bits of the power result (256x lsb)
  localparam int POWER_CMP_LSB = 8;

  // register offsets
  localparam logic [ADDR_W-1:0] JOULES_ADDR = 6'h09;
  localparam logic [ADDR_W-1:0] COULOMBS_ADDR = 6'h0A;
  localparam logic [ADDR_W-1:0] DIAG_ADDR = 6'h0B;

  // fault_flags_alert_config field positions
  localparam int LATCH_BIT = 15;
  localparam int READY_EN_BIT = 14;
  localparam int AVG_SEL_BIT = 13;
  localparam int SENSE_BIT = 12;
  localparam int JOULE_OF_BIT = 11;
  localparam int COULOMB_OF_BIT = 10;
  localparam int ARITH_OF_BIT = 9;
  localparam int RESERVED_BIT = 8;
  localparam int LIMIT_LSB = 2;
  localparam int CONV_DONE_BIT = 1;
  localparam int TRIM_OK_BIT = 0;

  // limit flag index inside the six-bit limit vector (diag bits 7..2)
  localparam int LIM_TEMP = 5;
  localparam int LIM_OC = 4;
  localparam int LIM_UC = 3;
  localparam int LIM_BOV = 2;
  localparam int LIM_BUV = 1;
  localparam int LIM_POW = 0;

  // accumulator channels
  localparam int CH_JOULE = 0;
  localparam int CH_COULOMB = 1;
  localparam int CH_N = 2;

  localparam logic [DIAG_W-1:0] DIAG_RESET = 16'h0001;
  localparam logic [ACC_W-1:0] ACC_ZERO = 40'h00_0000_0000;
endpackage : power_acc_pkg
`default_nettype wire

// File: hdl/accumulator_channel.sv
`timescale 1ns/1ps
`default_nettype none
module accumulator_channel
  import power_acc_pkg::*;
#(
  parameter bit IS_SIGNED = 1'b0
)
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  // control
  input wire logic clear_i,
  input wire logic add_i,
  input wire logic [ACC_W-1:0] delta_i,
  // state
  output logic [ACC_W-1:0] sum_o,
  output logic overflow_o
);
  logic [ACC_W-1:0] sum_reg;
  logic [ACC_W-1:0] sum_next;
  logic ovf_reg;
  logic ovf_next;
  wire logic [ACC_W:0] wide_sum = {1'b0, sum_reg} + {1'b0, delta_i};
  wire logic signed_ovf = (sum_reg[ACC_W-1] == delta_i[ACC_W-1]) &&
                          (wide_sum[ACC_W-1] != sum_reg[ACC_W-1]);
  wire logic unsigned_ovf = wide_sum[ACC_W];
  wire logic ovf_event = add_i && (IS_SIGNED ? signed_ovf : unsigned_ovf);

  // a clear in the same cycle as an add restarts from zero, so no overflow can occur
  assign sum_next = clear_i ? (add_i ? delta_i : ACC_ZERO) :
                    (add_i ? wide_sum[ACC_W-1:0] : sum_reg);
  assign ovf_next = clear_i ? 1'b0 : (ovf_reg | ovf_event);

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      sum_reg <= ACC_ZERO;
      ovf_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      sum_reg <= sum_next;
      ovf_reg <= ovf_next;
    end
  end

  assign sum_o = sum_reg;
  assign overflow_o = ovf_reg;
endmodule : accumulator_channel
`default_nettype wire

// File: hdl/accumulators_and_alert_flags.sv
// Notes on behaviour
// RL1 - energy total is a 40-bit unsigned read-only value, 3.84 mJ per step
// RL2 - charge total is 40-bit two's complement read-only, 75 uC per step, resets zero
// RL3 - latch off: alert pin and flags go idle once the fault disappears
// RL4 - latch on: alert pin and flags hold until the diag register is read
// RL5 - bit 14 set lets conversion-done drive the alert pin; clear blocks it
// RL6 - bit 13 picks averaged or raw results for the limit comparisons
// RL7 - bit 12 sets pin polarity: zero active-low, one active-high, both open-drain
// RL8 - bit 11 sets on energy overflow, clears only on accumulator clear
// RL9 - bit 10 sets on charge overflow, clears only on accumulator clear
// RL10 - bit 9 flags arithmetic overflow, clears on triggered conversion or accumulator clear
// RL11 - bit 8 is reserved and always reads zero
// RL12 - bit 7 sets when temperature exceeds its limit
// RL13 - bit 6 sets when current exceeds the overcurrent limit
// RL14 - bit 5 sets when current falls below the undercurrent limit
// RL15 - bit 4 sets when supply voltage exceeds its upper limit
// RL16 - bit 3 sets when supply voltage falls below its lower limit
// RL17 - bit 2 sets when power exceeds its limit
// RL18 - with latching, limit flags 7..2 clear on a diag register read
// RL19 - bit 1 sets on conversion done; clears on read or triggered start
// RL20 - bit 0 resets to one, drops to zero on trim checksum error
// RL21 - with averaging non-zero, results update only after the full average
// RL22 - limits are compared on each new selected result, flags set that update
// RL23 - accumulator clear zeroes both overflow flags and both totals, or loads the delta if a result update lands with it
`timescale 1ns/1ps
`default_nettype none
module accumulators_and_alert_flags
  import power_acc_pkg::*;
(
  // clock, reset, enable
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic reg_rd_i,
  input wire logic reg_wr_i,
  input wire logic [DIAG_W-1:0] reg_wdata_i,
  output logic [ACC_W-1:0] reg_rdata_o,
  output logic reg_rvalid_o,
  // measurement results
  input wire logic raw_valid_i,
  input wire logic avg_done_i,
  input wire logic [2:0] avg_count_i,
  input wire logic signed [CURRENT_W-1:0] current_i,
  input wire logic [VBUS_W-1:0] vbus_i,
  input wire logic signed [TEMP_W-1:0] temp_i,
  input wire logic [POWER_W-1:0] power_i,
  input wire logic arith_ovf_i,
  // limits
  input wire logic signed [CURRENT_W-1:0] over_current_limit_i,
  input wire logic signed [CURRENT_W-1:0] under_current_limit_i,
  input wire logic [VBUS_W-1:0] supply_upper_limit_i,
  input wire logic [VBUS_W-1:0] supply_lower_limit_i,
  input wire logic signed [TEMP_W-1:0] temp_limit_i,
  input wire logic [PLIMIT_W-1:0] power_limit_i,
  // control events
  input wire logic trig_start_i,
  input wire logic accumulator_clear_i,
  input wire logic trim_checksum_err_i,
  // alert pin
  output logic alert_pin_o,
  output logic alert_pin_oe_o
);
  // configuration and flag state
  logic alert_latch_select_reg;
  logic ready_on_alert_enable_reg;
  logic alert_on_averaged_reg;
  logic alert_pin_sense_reg;
  logic arith_overflow_flag_reg;
  logic arith_overflow_flag_next;
  logic [LIMIT_N-1:0] limit_flags_reg;
  logic [LIMIT_N-1:0] limit_flags_next;
  logic conversion_done_flag_reg;
  logic conversion_done_flag_next;
  logic trim_checksum_ok_reg;
  logic [ACC_W-1:0] rdata_reg;
  logic [ACC_W-1:0] rdata_next;
  logic rvalid_reg;
  logic alert_oe_reg;
  logic alert_out_reg;

  logic [ACC_W-1:0] acc_delta [CH_N];
  logic [ACC_W-1:0] acc_sum [CH_N];
  logic [CH_N-1:0] acc_ovf;

  // decode
  wire logic rd_diag = reg_rd_i && (reg_addr_i == DIAG_ADDR);
  wire logic wr_diag = reg_wr_i && (reg_addr_i == DIAG_ADDR);
  wire logic joule_acc_overflow_flag = acc_ovf[CH_JOULE];
  wire logic coulomb_acc_overflow_flag = acc_ovf[CH_COULOMB];

  // RL21 averaged strobe
  // with no averaging every raw result is already final
  wire logic avg_strobe = (avg_count_i == 3'h0) ? raw_valid_i : avg_done_i;
  wire logic result_update = avg_strobe;

  // RL6 comparison source
  wire logic cmp_strobe = alert_on_averaged_reg ? avg_strobe : raw_valid_i;

  // limit comparisons
  logic [LIMIT_N-1:0] violation;
  // RL12 over temperature
  assign violation[LIM_TEMP] = temp_i > temp_limit_i;
  // RL13 over current
  assign violation[LIM_OC] = current_i > over_current_limit_i;
  // RL14 under current
  assign violation[LIM_UC] = current_i < under_current_limit_i;
  // RL15 supply over limit
  assign violation[LIM_BOV] = vbus_i > supply_upper_limit_i;
  // RL16 supply under limit
  assign violation[LIM_BUV] = vbus_i < supply_lower_limit_i;
  // RL17 power over limit
  assign violation[LIM_POW] = power_i[POWER_W-1:POWER_CMP_LSB] > power_limit_i;

  // RL22 flag on comparison
  wire logic [LIMIT_N-1:0] new_hits = cmp_strobe ? violation : {LIMIT_N{1'b0}};
  // RL4 latched hold
  // RL18 read clears latched
  // set wins over a read that lands in the same cycle
  wire logic [LIMIT_N-1:0] latched_flags =
    new_hits | (rd_diag ? {LIMIT_N{1'b0}} : limit_flags_reg);
  // RL3 transparent follow
  wire logic [LIMIT_N-1:0] transparent_flags = cmp_strobe ? violation : limit_flags_reg;
  assign limit_flags_next = alert_latch_select_reg ? latched_flags : transparent_flags;

  // RL19 conversion done flag
  wire logic conv_clear = rd_diag || trig_start_i;
  assign conversion_done_flag_next =
    result_update || (conv_clear ? 1'b0 : conversion_done_flag_reg);

  // RL10 arithmetic overflow
  wire logic arith_clear = trig_start_i || accumulator_clear_i;
  assign arith_overflow_flag_next =
    arith_ovf_i || (arith_clear ? 1'b0 : arith_overflow_flag_reg);

  // RL5 ready on pin
  wire logic alert_active = (|limit_flags_reg) ||
                            (ready_on_alert_enable_reg && conversion_done_flag_reg);
  // RL7 polarity
  // active-high open-drain releases the pin when active, pulls low when idle
  wire logic alert_oe_next = alert_active ^ alert_pin_sense_reg;

  // read image of the diag register, reserved bit forced low
  logic [DIAG_W-1:0] diag_word;
  always_comb
  begin
    diag_word = {DIAG_W{1'b0}};
    diag_word[LATCH_BIT] = alert_latch_select_reg;
    diag_word[READY_EN_BIT] = ready_on_alert_enable_reg;
    diag_word[AVG_SEL_BIT] = alert_on_averaged_reg;
    diag_word[SENSE_BIT] = alert_pin_sense_reg;
    diag_word[JOULE_OF_BIT] = joule_acc_overflow_flag;
    diag_word[COULOMB_OF_BIT] = coulomb_acc_overflow_flag;
    diag_word[ARITH_OF_BIT] = arith_overflow_flag_reg;
    // RL11 reserved zero
    diag_word[RESERVED_BIT] = 1'b0;
    diag_word[LIMIT_LSB +: LIMIT_N] = limit_flags_reg;
    diag_word[CONV_DONE_BIT] = conversion_done_flag_reg;
    diag_word[TRIM_OK_BIT] = trim_checksum_ok_reg;
  end

  // read mux, unmapped offsets read zero
  // RL1 energy readback
  // RL2 charge readback
  assign rdata_next =
    (reg_addr_i == JOULES_ADDR) ? acc_sum[CH_JOULE] :
    (reg_addr_i == COULOMBS_ADDR) ? acc_sum[CH_COULOMB] :
    (reg_addr_i == DIAG_ADDR) ? {{(ACC_W-DIAG_W){1'b0}}, diag_word} : ACC_ZERO;

  // accumulator deltas: power is unsigned, current sign-extended
  assign acc_delta[CH_JOULE] = {{(ACC_W-POWER_W){1'b0}}, power_i};
  assign acc_delta[CH_COULOMB] = {{(ACC_W-CURRENT_W){current_i[CURRENT_W-1]}}, current_i};

  // RL8 energy overflow
  // RL9 charge overflow
  // RL23 clear both totals
  genvar ch;
  generate
    for (ch = 0; ch < CH_N; ch++)
    begin : g_acc
      accumulator_channel #(
        .IS_SIGNED(ch == CH_COULOMB)
      ) u_acc (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .ce_i(ce_i),
        .clear_i(accumulator_clear_i),
        .add_i(result_update),
        .delta_i(acc_delta[ch]),
        .sum_o(acc_sum[ch]),
        .overflow_o(acc_ovf[ch])
      );
    end
  endgenerate

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      alert_latch_select_reg <= DIAG_RESET[LATCH_BIT];
      ready_on_alert_enable_reg <= DIAG_RESET[READY_EN_BIT];
      alert_on_averaged_reg <= DIAG_RESET[AVG_SEL_BIT];
      alert_pin_sense_reg <= DIAG_RESET[SENSE_BIT];
    end
    else if (ce_i && wr_diag)
    begin
      alert_latch_select_reg <= reg_wdata_i[LATCH_BIT];
      ready_on_alert_enable_reg <= reg_wdata_i[READY_EN_BIT];
      alert_on_averaged_reg <= reg_wdata_i[AVG_SEL_BIT];
      alert_pin_sense_reg <= reg_wdata_i[SENSE_BIT];
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      limit_flags_reg <= DIAG_RESET[LIMIT_LSB +: LIMIT_N];
      conversion_done_flag_reg <= DIAG_RESET[CONV_DONE_BIT];
      arith_overflow_flag_reg <= DIAG_RESET[ARITH_OF_BIT];
    end
    else if (ce_i)
    begin
      limit_flags_reg <= limit_flags_next;
      conversion_done_flag_reg <= conversion_done_flag_next;
      arith_overflow_flag_reg <= arith_overflow_flag_next;
    end
  end

  // RL20 trim checksum status
  // sticky until reset: a trim fault is not something software can repair
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
      trim_checksum_ok_reg <= DIAG_RESET[TRIM_OK_BIT];
    else if (ce_i && trim_checksum_err_i)
      trim_checksum_ok_reg <= 1'b0;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      rdata_reg <= ACC_ZERO;
      rvalid_reg <= 1'b0;
      alert_oe_reg <= 1'b0;
      alert_out_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      if (reg_rd_i)
        rdata_reg <= rdata_next;
      rvalid_reg <= reg_rd_i;
      alert_oe_reg <= alert_oe_next;
      alert_out_reg <= 1'b0;
    end
  end

  assign reg_rdata_o = rdata_reg;
  assign reg_rvalid_o = rvalid_reg;
  assign alert_pin_o = alert_out_reg;
  assign alert_pin_oe_o = alert_oe_reg;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_conv_done;
    ce_i && result_update;
  endsequence

  sequence s_clean_read;
    ce_i && rd_diag && !result_update && !trig_start_i;
  endsequence

  latch_hold_a: assert property ( // RL4
    ce_i && alert_latch_select_reg && limit_flags_reg[LIM_OC] && !rd_diag
    |=> limit_flags_reg[LIM_OC])
    else $error("latched overcurrent flag dropped without a read");

  transparent_drop_a: assert property ( // RL3
    ce_i && !alert_latch_select_reg && cmp_strobe && (violation == 6'h00)
    |=> (limit_flags_reg == 6'h00))
    else $error("transparent flags did not return to idle");

  read_clear_a: assert property ( // RL18
    ce_i && alert_latch_select_reg && rd_diag && !cmp_strobe
    |=> (limit_flags_reg == 6'h00))
    else $error("latched limit flags not cleared by read");

  conv_read_a: assert property ( // RL19
    s_conv_done ##1 s_clean_read |=> !conversion_done_flag_reg)
    else $error("conversion done flag survived read");

  ready_pin_a: assert property ( // RL5
    ce_i && ready_on_alert_enable_reg && conversion_done_flag_reg && !alert_pin_sense_reg
    |=> alert_pin_oe_o && !alert_pin_o)
    else $error("conversion done did not reach alert pin");

  polarity_a: assert property ( // RL7
    ce_i && !alert_active && alert_pin_sense_reg |=> alert_pin_oe_o)
    else $error("active-high idle pin not pulled low");

  joule_ovf_hold_a: assert property ( // RL8
    ce_i && joule_acc_overflow_flag && !accumulator_clear_i
    |=> joule_acc_overflow_flag)
    else $error("energy overflow flag cleared without accumulator clear");

  acc_clear_a: assert property ( // RL23
    ce_i && accumulator_clear_i && !result_update
    |=> (acc_sum[CH_JOULE] == ACC_ZERO) && (acc_sum[CH_COULOMB] == ACC_ZERO) &&
        (acc_ovf == 2'h0))
    else $error("accumulator clear left state behind");

  arith_clear_a: assert property ( // RL10
    ce_i && arith_clear && !arith_ovf_i |=> !arith_overflow_flag_reg)
    else $error("arithmetic overflow flag not cleared");

  reserved_zero_a: assert property ( // RL11
    reg_rvalid_o && $past(rd_diag) && $past(ce_i) |-> !reg_rdata_o[RESERVED_BIT])
    else $error("reserved diag bit read as one");

  trim_drop_a: assert property ( // RL20
    ce_i && trim_checksum_err_i |=> !trim_checksum_ok_reg ##1 !trim_checksum_ok_reg)
    else $error("trim status did not drop on checksum error");

  avg_hold_a: assert property ( // RL21
    ce_i && !result_update && !accumulator_clear_i |=> $stable(acc_sum[CH_JOULE]))
    else $error("energy total moved without a final result");

  coulomb_ovf_hold_a: assert property ( // RL9
    ce_i && coulomb_acc_overflow_flag && !accumulator_clear_i
    |=> coulomb_acc_overflow_flag)
    else $error("charge overflow flag cleared without accumulator clear");

  hit_sets_a: assert property ( // RL22
    ce_i && cmp_strobe |=> ((limit_flags_reg & $past(violation)) == $past(violation)))
    else $error("limit violation not flagged in the same update");

  conv_set_a: assert property ( // RL19
    ce_i && result_update |=> conversion_done_flag_reg)
    else $error("conversion done flag not set by a final result");

  ready_block_a: assert property ( // RL5
    ce_i && !ready_on_alert_enable_reg && !(|limit_flags_reg) && !alert_pin_sense_reg
    |=> !alert_pin_oe_o)
    else $error("conversion done reached the pin while disabled");
endmodule : accumulators_and_alert_flags
`default_nettype wire

// File: sim/register_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module register_host_model
  import power_acc_pkg::*;
(
  // clock
  input wire logic clk_sys_i,
  // register port towards the device
  output logic [ADDR_W-1:0] reg_addr_o,
  output logic reg_rd_o,
  output logic reg_wr_o,
  output logic [DIAG_W-1:0] reg_wdata_o,
  input wire logic [ACC_W-1:0] reg_rdata_i,
  input wire logic reg_rvalid_i,
  // open-drain alert wire
  input wire logic alert_pin_i,
  input wire logic alert_pin_oe_i,
  output logic alert_level_o
);
  // board pull-up holds the wire high when nobody sinks it
  assign alert_level_o = alert_pin_oe_i ? alert_pin_i : 1'b1;

  initial
  begin
    reg_addr_o = '0;
    reg_rd_o = 1'b0;
    reg_wr_o = 1'b0;
    reg_wdata_o = '0;
  end

  task automatic do_write(input logic [ADDR_W-1:0] a, input logic [DIAG_W-1:0] d);
    @(posedge clk_sys_i);
    reg_addr_o <= a;
    reg_wdata_o <= d;
    reg_wr_o <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_o <= 1'b0;
    // stale data must not look valid after the strobe
    reg_wdata_o <= ~d;
  endtask : do_write

  task automatic do_read(input logic [ADDR_W-1:0] a, output logic [ACC_W-1:0] q);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    reg_addr_o <= a;
    reg_rd_o <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_o <= 1'b0;
    #1;
    while (reg_rvalid_i !== 1'b1 && n < 4)
    begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end
    q = (reg_rvalid_i === 1'b1) ? reg_rdata_i : {ACC_W{1'bx}};
  endtask : do_read
endmodule : register_host_model
`default_nettype wire

// File: sim/accumulators_and_alert_flags_tb.sv
`timescale 1ns/1ps
`default_nettype none
module accumulators_and_alert_flags_tb
  import power_acc_pkg::*;
;
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [ADDR_W-1:0] addr;
  logic rd, wr, rvalid, pin_d, pin_oe, level;
  logic [DIAG_W-1:0] wdata;
  logic [ACC_W-1:0] rdata;
  logic [1:0] st = '0;
  logic [3:0] ev = '0;
  logic [2:0] avg_count = '0;
  logic signed [15:0] cur = '0;
  logic [14:0] vb = '0;
  logic signed [11:0] tp = '0;
  logic [23:0] pw = '0;
  logic signed [15:0] ocl = 16'sh1000, ucl = -16'sh1000;
  logic [14:0] bovl = 15'h5000, buvl = 15'h2000;
  logic signed [11:0] tl = 12'sh200;
  logic [15:0] pl = 16'h8000;
  logic [5:0] f;
  logic ce = 1'b1;
  logic signed [15:0] rc;
  logic [14:0] rv;
  logic signed [11:0] rt;
  logic [23:0] rp;
  int failures = 0, num_checks = 0, cycles = 0;
  localparam logic [39:0] ALL = {40{1'b1}};

  accumulators_and_alert_flags u_accumulators_and_alert_flags (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .ce_i(ce),
    .reg_addr_i(addr), .reg_rd_i(rd), .reg_wr_i(wr), .reg_wdata_i(wdata),
    .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
    .raw_valid_i(st[0]), .avg_done_i(st[1]), .avg_count_i(avg_count),
    .current_i(cur), .vbus_i(vb), .temp_i(tp), .power_i(pw), .arith_ovf_i(ev[2]),
    .over_current_limit_i(ocl), .under_current_limit_i(ucl),
    .supply_upper_limit_i(bovl), .supply_lower_limit_i(buvl),
    .temp_limit_i(tl), .power_limit_i(pl),
    .trig_start_i(ev[1]), .accumulator_clear_i(ev[0]), .trim_checksum_err_i(ev[3]),
    .alert_pin_o(pin_d), .alert_pin_oe_o(pin_oe));

  register_host_model u_register_host_model (
    .clk_sys_i(clk_sys_i), .reg_addr_o(addr), .reg_rd_o(rd), .reg_wr_o(wr),
    .reg_wdata_o(wdata), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid),
    .alert_pin_i(pin_d), .alert_pin_oe_i(pin_oe), .alert_level_o(level));

  initial
  begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  function automatic logic [5:0] exp_lim(logic signed [15:0] c, logic [14:0] v,
      logic signed [11:0] t, logic [23:0] p);
    return {t > tl, c > ocl, c < ucl, v > bovl, v < buvl, p[23:8] > pl};
  endfunction : exp_lim

  task automatic final_report();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : final_report

  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic rd_chk(input logic [5:0] a, input logic [39:0] m, input logic [39:0] e);
    logic [39:0] q;
    u_register_host_model.do_read(a, q);
    check(q & m, e & m);
  endtask : rd_chk

  task automatic wr_diag(input logic [15:0] d);
    u_register_host_model.do_write(DIAG_ADDR, d);
  endtask : wr_diag

  // bit k of the event vector: 0 clear, 1 trigger, 2 arith, 3 trim
  task automatic pulse(input int k);
    @(posedge clk_sys_i);
    ev[k] <= 1'b1;
    @(posedge clk_sys_i);
    ev <= '0;
  endtask : pulse

  // defaults are a result inside every limit
  task automatic strobe(input int k, input logic [15:0] c = 16'h0000,
      input logic [14:0] v = 15'h3000, input logic [11:0] t = 12'h000,
      input logic [23:0] p = 24'h000000);
    @(posedge clk_sys_i);
    cur <= c;
    vb <= v;
    tp <= t;
    pw <= p;
    st[k] <= 1'b1;
    @(posedge clk_sys_i);
    st <= '0;
    @(posedge clk_sys_i);
    #1;
  endtask : strobe

  always @(posedge clk_sys_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 80000)
    begin
      failures++;
      final_report();
    end
  end

  initial
  begin
    void'($urandom(13));
    repeat (5) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    rd_chk(JOULES_ADDR, ALL, 40'h0);
    rd_chk(COULOMBS_ADDR, ALL, 40'h0);
    rd_chk(DIAG_ADDR, ALL, 40'h0001);
    rd_chk(6'h3E, ALL, 40'h0);
    check(level, 1'b1);
    wr_diag(16'hFFFF);
    rd_chk(DIAG_ADDR, 40'hFF00, 40'hF000);
    wr_diag(16'h0000);
    for (int i = 0; i < 40; i++)
    begin
      rc = 16'($urandom);
      rv = 15'($urandom);
      rt = 12'($urandom);
      rp = 24'($urandom);
      f = exp_lim(rc, rv, rt, rp);
      strobe(0, rc, rv, rt, rp);
      check(level, ~|f);
      rd_chk(DIAG_ADDR, 40'hFC, {32'h0, f, 2'b00});
    end
    strobe(0);
    check(level, 1'b1);
    // a frozen enable must swallow the strobe
    @(posedge clk_sys_i);
    ce <= 1'b0;
    strobe(0, 16'h7FFF);
    @(posedge clk_sys_i);
    ce <= 1'b1;
    rd_chk(DIAG_ADDR, 40'h40, 40'h00);
    wr_diag(16'h8000);
    strobe(0, 16'h7FFF);
    strobe(0);
    check(level, 1'b0);
    rd_chk(DIAG_ADDR, 40'h40, 40'h40);
    rd_chk(DIAG_ADDR, 40'h40, 40'h00);
    check(level, 1'b1);
    wr_diag(16'hC000);
    strobe(0);
    check(level, 1'b0);
    rd_chk(DIAG_ADDR, 40'h02, 40'h02);
    rd_chk(DIAG_ADDR, 40'h02, 40'h00);
    check(level, 1'b1);
    strobe(0);
    pulse(1);
    rd_chk(DIAG_ADDR, 40'h02, 40'h00);
    wr_diag(16'h8000);
    strobe(0);
    check(level, 1'b1);
    wr_diag(16'h1000);
    strobe(0);
    check(pin_oe, 1'b1);
    strobe(0, 16'h7FFF);
    check(pin_oe, 1'b0);
    // transparent flags hold until the next compare, so clear them first
    strobe(0);
    check(pin_oe, 1'b1);
    wr_diag(16'h2000);
    avg_count <= 3'd2;
    pulse(0);
    strobe(0, 16'h7FFF, 15'h3000, 12'h000, 24'h000100);
    rd_chk(DIAG_ADDR, 40'h40, 40'h00);
    rd_chk(JOULES_ADDR, ALL, 40'h0);
    strobe(1, 16'h7FFF, 15'h3000, 12'h000, 24'h000100);
    rd_chk(DIAG_ADDR, 40'h40, 40'h40);
    rd_chk(JOULES_ADDR, ALL, 40'h100);
    wr_diag(16'h0000);
    strobe(0);
    rd_chk(DIAG_ADDR, 40'h40, 40'h00);
    rd_chk(JOULES_ADDR, ALL, 40'h100);
    avg_count <= 3'd0;
    pulse(2);
    rd_chk(DIAG_ADDR, 40'h200, 40'h200);
    pulse(1);
    rd_chk(DIAG_ADDR, 40'h200, 40'h000);
    pulse(0);
    @(posedge clk_sys_i);
    pw <= 24'hFFFFFF;
    cur <= -16'sd3;
    st[0] <= 1'b1;
    // just enough full-scale adds to carry out of 40 bits once
    repeat (65537) @(posedge clk_sys_i);
    st <= '0;
    rd_chk(JOULES_ADDR, ALL, 40'h00_00FE_FFFF);
    rd_chk(COULOMBS_ADDR, ALL, 40'(-64'sd3 * 64'sd65537));
    rd_chk(DIAG_ADDR, 40'hC00, 40'h800);
    pulse(0);
    rd_chk(JOULES_ADDR, ALL, 40'h0);
    rd_chk(COULOMBS_ADDR, ALL, 40'h0);
    rd_chk(DIAG_ADDR, 40'hC00, 40'h000);
    pulse(3);
    rd_chk(DIAG_ADDR, 40'h01, 40'h00);
    final_report();
  end
endmodule : accumulators_and_alert_flags_tb
`default_nettype wire
